// >>> src/usb_flags.sv
// USB interrupt flag and error enable block with an APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "usb_flags_regs.svh"
module usb_flags #(
  parameter int IDLE_COUNT = `IDLE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // USB link events
  input wire usb_flags_pkg::line_state_t line_state,
  input wire logic low_speed,
  input wire logic bus_activity,
  input wire logic in_bus_reset,
  input wire logic stall_sent,
  input wire logic token_done,
  input wire logic sof_event,
  input wire logic detach_event,
  input wire logic [7:0] error_events,
  // Interrupt
  output logic usb_irq
);
  import usb_flags_pkg::*;

  // ==========================================================================
  // State
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] err_en_reg;
  logic [7:0] err_en_next;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [7:0] err_stat_reg;
  logic [7:0] err_stat_next;
  logic detach_lock_reg;
  logic detach_lock_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic word_wr;
  logic attach_hit;
  logic resume_hit;
  logic idle_hit;
  logic k_state;
  logic idle_state;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;

  // ==========================================================================
  // Line timers
  assign k_state = low_speed ? (line_state == LINE_J) : (line_state == LINE_K);
  assign idle_state = low_speed ? (line_state == LINE_K) : (line_state == LINE_J);

  hold_timer #(.COUNT(`ATTACH_CYCLES)) attach_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cond(line_state != LINE_SE0 && !bus_activity),
    .reached(attach_hit)
  );

  hold_timer #(.COUNT(`RESUME_CYCLES)) resume_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cond(k_state),
    .reached(resume_hit)
  );

  hold_timer #(.COUNT(IDLE_COUNT)) idle_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cond(idle_state && !bus_activity),
    .reached(idle_hit)
  );

  // ==========================================================================
  // Bus decode
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign addr_ok = paddr == `FLAGS_OFFSET || paddr == `ERR_EN_OFFSET ||
                   paddr == `IRQ_MASK_OFFSET || paddr == `ERR_STATUS_OFFSET;
  // A flags or error status write without both pstrb[0] and pstrb[1] is ignored so that a byte write never clears flags.
  assign word_wr = wr_acc && pstrb[0] && pstrb[1];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_comb
  begin
    set_vec = 8'h00;
    set_vec[`STALL_BIT] = stall_sent;
    set_vec[`ATTACH_BIT] = attach_hit;
    set_vec[`RESUME_BIT] = resume_hit;
    set_vec[`IDLE_BIT] = idle_hit;
    set_vec[`TOKEN_BIT] = token_done;
    set_vec[`SOF_BIT] = sof_event;
    set_vec[`ERROR_BIT] = |(error_events & err_en_reg);
    set_vec[`DETACH_BIT] = detach_event && !detach_lock_reg;
    clr_vec = 8'h00;
    if (word_wr && paddr == `FLAGS_OFFSET)
      clr_vec = pwdata[7:0];
  end

  // ==========================================================================
  // Registers
  always_comb
  begin
    flags_next = (flags_reg & ~clr_vec) | set_vec;
    err_stat_next = err_stat_reg | error_events;
    if (word_wr && paddr == `ERR_STATUS_OFFSET)
      err_stat_next = (err_stat_reg & ~pwdata[7:0]) | error_events;
    detach_lock_next = detach_lock_reg;
    if (detach_event)
      detach_lock_next = 1'b1;
    else if (!in_bus_reset)
      detach_lock_next = 1'b0;
    err_en_next = err_en_reg;
    if (wr_acc && paddr == `ERR_EN_OFFSET && pstrb[0])
      err_en_next = pwdata[7:0] & `ERR_EN_IMPL;
    mask_next = mask_reg;
    if (wr_acc && paddr == `IRQ_MASK_OFFSET && pstrb[0])
      mask_next = pwdata[7:0];
    prdata_next = prdata_reg;
    if (rd_acc)
    begin
      unique case (paddr)
        `FLAGS_OFFSET: prdata_next = {24'h000000, flags_reg};
        `ERR_EN_OFFSET: prdata_next = {24'h000000, err_en_reg};
        `IRQ_MASK_OFFSET: prdata_next = {24'h000000, mask_reg};
        `ERR_STATUS_OFFSET: prdata_next = {24'h000000, err_stat_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      flags_reg <= `FLAGS_RESET;
      err_en_reg <= `ERR_EN_RESET;
      mask_reg <= `IRQ_MASK_RESET;
      err_stat_reg <= 8'h00;
      detach_lock_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      flags_reg <= flags_next;
      err_en_reg <= err_en_next;
      mask_reg <= mask_next;
      err_stat_reg <= err_stat_next;
      detach_lock_reg <= detach_lock_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  // Level request while any enabled flag stands.
  assign usb_irq = |(flags_reg & mask_reg);

  // ==========================================================================
  // Checks
  stall_sets_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    stall_sent |=> flags_reg[`STALL_BIT]) else $error("stall flag not set");
  attach_sets_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    attach_hit |=> flags_reg[`ATTACH_BIT]) else $error("attach flag not set");
  resume_sets_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    resume_hit |=> flags_reg[`RESUME_BIT]) else $error("resume flag not set");
  token_sets_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    token_done |=> flags_reg[`TOKEN_BIT]) else $error("token flag not set");
  masked_error_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!flags_reg[`ERROR_BIT] && !(|(error_events & err_en_reg)))
    |=> !flags_reg[`ERROR_BIT]) else $error("masked error set flag");
  detach_lock_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (detach_lock_reg && in_bus_reset && !flags_reg[`DETACH_BIT])
    |=> !flags_reg[`DETACH_BIT]) else $error("detach flag reasserted");
  zero_keeps_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (flags_reg[`SOF_BIT] && !clr_vec[`SOF_BIT]) |=> flags_reg[`SOF_BIT])
    else $error("flag lost without clear");
  upper_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(rd_acc) |-> prdata[31:16] == 16'h0000) else $error("upper bits nonzero");
  irq_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ((|(set_vec & mask_reg)) && !(wr_acc && paddr == `IRQ_MASK_OFFSET))
    |=> usb_irq) else $error("irq not raised");
  en_reserved_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !err_en_reg[6]) else $error("unused enable bit set");
  stall_cov_c: cover property (@(posedge ref_clk) stall_sent ##1 usb_irq);
  clear_cov_c: cover property (@(posedge ref_clk) flags_reg != 8'h00 ##1 word_wr);
  idle_cov_c: cover property (@(posedge ref_clk) idle_hit);
endmodule : usb_flags
`default_nettype wire

// >>> src/usb_flags_regs.svh
// Register offsets, field positions, reset values and timing counts of the USB flag block.
`ifndef USB_FLAGS_REGS_SVH
`define USB_FLAGS_REGS_SVH
// ==========================================================================
// Register map (byte addresses)
`define FLAGS_OFFSET 12'h000
`define ERR_EN_OFFSET 12'h004
`define IRQ_MASK_OFFSET 12'h008
`define ERR_STATUS_OFFSET 12'h00c
`define LINK_CTRL_OFFSET 12'h010
// ==========================================================================
// Flag bit positions
`define STALL_BIT 7
`define ATTACH_BIT 6
`define RESUME_BIT 5
`define IDLE_BIT 4
`define TOKEN_BIT 3
`define SOF_BIT 2
`define ERROR_BIT 1
`define DETACH_BIT 0
// ==========================================================================
// Reset values and masks
`define FLAGS_RESET 8'h00
`define ERR_EN_RESET 8'h00
`define IRQ_MASK_RESET 8'h00
`define ERR_EN_IMPL 8'hbf
// ==========================================================================
// Timing
`define CLK_MHZ 50
`define ATTACH_TIME_NS 2500
`define RESUME_TIME_NS 2500
`define IDLE_TIME_US 3000
`define ATTACH_CYCLES ((`ATTACH_TIME_NS * `CLK_MHZ + 999) / 1000)
`define RESUME_CYCLES ((`RESUME_TIME_NS * `CLK_MHZ + 999) / 1000)
`define IDLE_CYCLES (`IDLE_TIME_US * `CLK_MHZ)
`endif

// >>> src/usb_flags_pkg.sv
// Types shared by the USB flag block.
package usb_flags_pkg;
  typedef enum logic [1:0] {
    LINE_SE0 = 2'h0,
    LINE_J = 2'h1,
    LINE_K = 2'h2,
    LINE_SE1 = 2'h3
  } line_state_t;
endpackage : usb_flags_pkg

// >>> src/hold_timer.sv
// Counter that reports when a condition has held for a number of cycles.
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
  parameter int COUNT = 125
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Condition
  input wire logic cond,
  output logic reached
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic fired_reg;
  logic fired_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    fired_next = fired_reg;
    if (!cond)
    begin
      cnt_next = '0;
      fired_next = 1'b0;
    end
    else if (cnt_reg != W'(COUNT))
      cnt_next = cnt_reg + W'(1);
    if (cond && cnt_reg == W'(COUNT - 1))
      fired_next = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      cnt_reg <= '0;
      fired_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      fired_reg <= fired_next;
    end
  end

  // One pulse, once per unbroken stretch of the condition.
  assign reached = cond && cnt_reg == W'(COUNT - 1) && !fired_reg;
endmodule : hold_timer
`default_nettype wire

// >>> verification/usb_link_model.sv
// Model of the USB link side that feeds bus states and event pulses.
`timescale 1ns/1ps
`default_nettype none
module usb_link_model
  import usb_flags_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Line
  output var line_state_t line_state,
  output logic low_speed,
  output logic bus_activity,
  output logic in_bus_reset,
  // Events
  output logic stall_sent,
  output logic token_done,
  output logic sof_event,
  output logic detach_event,
  output logic [7:0] error_events
);
  // ==========================================================
  // Drivers
  initial
  begin
    line_state = LINE_SE0;
    low_speed = 1'b0;
    bus_activity = 1'b1;
    in_bus_reset = 1'b0;
    {stall_sent, token_done, sof_event, detach_event} = 4'h0;
    error_events = 8'h00;
  end
  // Events last one cycle, so a slow flag capture would miss them.
  task automatic pulse(input logic [3:0] ev, input logic [7:0] err, input logic rst);
    @(posedge ref_clk);
    {stall_sent, token_done, sof_event, detach_event} <= ev;
    error_events <= err;
    in_bus_reset <= rst;
    @(posedge ref_clk);
    {stall_sent, token_done, sof_event, detach_event} <= 4'h0;
    error_events <= 8'h00;
  endtask : pulse
  task automatic speed(input logic ls);
    @(posedge ref_clk);
    low_speed <= ls;
  endtask : speed
  task automatic hold(input line_state_t st, input logic act, input int n);
    @(posedge ref_clk);
    line_state <= st;
    bus_activity <= act;
    repeat (n) @(posedge ref_clk);
  endtask : hold
endmodule : usb_link_model
`default_nettype wire

// >>> verification/tb.sv
// Self-checking testbench of the USB interrupt flag block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import usb_flags_pkg::*;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, usb_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  line_state_t line_state;
  logic low_speed, bus_activity, in_bus_reset, stall_sent, token_done;
  logic sof_event, detach_event;
  logic [7:0] error_events;
  int num_errors = 0;
  int compares = 0;
  usb_flags #(.IDLE_COUNT(50)) usb_flags_inst (.ref_clk(ref_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_state(line_state), .low_speed(low_speed), .bus_activity(bus_activity),
    .in_bus_reset(in_bus_reset), .stall_sent(stall_sent), .token_done(token_done),
    .sof_event(sof_event), .detach_event(detach_event), .error_events(error_events),
    .usb_irq(usb_irq));
  usb_link_model m (.ref_clk(ref_clk), .line_state(line_state), .low_speed(low_speed),
    .bus_activity(bus_activity), .in_bus_reset(in_bus_reset), .stall_sent(stall_sent),
    .token_done(token_done), .sof_event(sof_event), .detach_event(detach_event),
    .error_events(error_events));
  // ==========================================================
  // Bus tasks
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(n, r, x);
  endtask : rd
  task automatic irq(input logic x);
    #1;
    check("irq", {31'h0, usb_irq}, {31'h0, x});
  endtask : irq
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd("flags", 12'h000, 32'h0);
    rd("err_en", 12'h004, 32'h0);
    irq(1'b0);
    wr(12'h004, 32'hffffffff);
    rd("err_en", 12'h004, 32'hbf);
    apb(1'b0, 12'h020, 32'h0, r, e);
    check("unmapped", {e, r[30:0]}, 32'h80000000);
  endtask : t_reset
  task automatic t_events();
    m.pulse(4'hf, 8'h00, 1'b0);
    rd("flags", 12'h000, 32'h8d);
    wr(12'h000, 32'h0);
    rd("flags", 12'h000, 32'h8d);
    wr(12'h000, 32'hffffff08);
    rd("flags", 12'h000, 32'h85);
  endtask : t_events
  task automatic t_errors();
    for (int i = 0; i < 8; i++)
    begin
      if (i == 6)
        continue;
      wr(12'h004, 32'h1 << i);
      wr(12'h000, 32'hff);
      m.pulse(4'h0, ~(8'h1 << i) & 8'hbf, 1'b0);
      rd("masked", 12'h000, 32'h0);
      m.pulse(4'h0, 8'h1 << i, 1'b0);
      rd("enabled", 12'h000, 32'h2);
    end
  endtask : t_errors
  task automatic t_irq();
    irq(1'b0);
    wr(12'h008, 32'h2);
    irq(1'b1);
    wr(12'h008, 32'hfd);
    irq(1'b0);
    wr(12'h008, 32'h2);
    wr(12'h000, 32'h2);
    irq(1'b0);
  endtask : t_irq
  task automatic t_timers();
    m.hold(LINE_J, 1'b0, 40);
    rd("idle", 12'h000, 32'h0);
    m.hold(LINE_J, 1'b0, 20);
    rd("idle", 12'h000, 32'h10);
    m.hold(LINE_J, 1'b0, 70);
    rd("attach", 12'h000, 32'h50);
    m.hold(LINE_J, 1'b1, 130);
    wr(12'h000, 32'hff);
    rd("busy", 12'h000, 32'h0);
    m.hold(LINE_K, 1'b0, 130);
    rd("resume", 12'h000, 32'h60);
    m.hold(LINE_SE0, 1'b0, 130);
    wr(12'h000, 32'hff);
    rd("se0", 12'h000, 32'h0);
    m.speed(1'b1);
    m.hold(LINE_J, 1'b0, 130);
    rd("low_speed", 12'h000, 32'h60);
    m.hold(LINE_SE0, 1'b1, 1);
    m.speed(1'b0);
    wr(12'h000, 32'hff);
    rd("ls_clear", 12'h000, 32'h0);
  endtask : t_timers
  task automatic t_detach();
    m.pulse(4'h1, 8'h00, 1'b1);
    rd("detach", 12'h000, 32'h1);
    wr(12'h000, 32'h1);
    m.pulse(4'h1, 8'h00, 1'b1);
    rd("relock", 12'h000, 32'h0);
    m.pulse(4'h0, 8'h00, 1'b0);
    m.pulse(4'h1, 8'h00, 1'b0);
    rd("rearm", 12'h000, 32'h1);
  endtask : t_detach
  // ==========================================================
  // Run control
  task automatic report_and_stop();
    if (num_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial
  begin
    #2000000;
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_events();
    t_errors();
    t_irq();
    t_timers();
    t_detach();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
